// ===== hdl/rssops_core.sv
// Purpose: Rotate, subtract-with-borrow and decrement-skip execution slice.
// Assumes: APB slave, zero wait states; memory byte held as a register.
// Notes: A command write starts one operation; skip adds a dummy cycle.
// Notes: Writes land at the access edge; refusal is judged at setup.
// Notes: Unused op codes take one busy cycle and change nothing.
// Behaviour
// RULE1: Rotate right through borrow into work
// RULE2: Rotate writes work only, alters borrow only
// RULE3: Work minus memory minus inverted borrow
// RULE4: Borrow clear if negative, else set
// RULE5: Immediate form subtracts constant into work
// RULE6: Memory-target form writes difference to memory
// RULE7: Subtracts update all six status flags
// RULE8: Decrement memory, skip next when zero
// RULE9: Decrement-skip takes two instruction cycles; the core takes two busy cycles only on a skip, one otherwise
// RULE10: Decrement into work, memory kept, skip
// RULE11: Decrement-skip alters no flags
// RULE12: Dummy cycle changes nothing
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`include "rssops_regs.svh"

module rssops_core
  import rssops_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core status
  output logic busy,
  output logic skip_cycle
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] work_reg, work_next;
  logic [7:0] mem_reg, mem_next;
  rssops_flags_t flag_reg, flag_next;
  rssops_op_t op_reg, op_next;
  logic [7:0] imm_reg, imm_next;
  rssops_state_t state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  // Bus phase and decode strobes
  logic setup_wr, setup_rd, wr_commit, hit;
  logic refuse, cmd_start;
  // Datapath results for rotate and decrement
  logic skip_req, dec_zero, rot_borrow;
  logic [7:0] rot_res;
  // Read multiplexer words
  logic [31:0] rd_word, stat_word;
  logic [7:0] operand, sub_res, dec_src, dec_res;
  logic [8:0] diff9;
  logic [4:0] low5;
  logic sub_ov;
  rssops_flags_t sub_flags;

  ////////////////////////////////////////////////////////////////////////
  // APB phases: refusal and read data are judged at the setup edge
  assign setup_wr = psel & ~penable & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign refuse = (setup_wr & (~hit | busy)) | (setup_rd & ~hit);

  // Writes land at the access edge, and only when not refused
  assign wr_commit = psel & penable & pready & pwrite & ~err_reg;
  assign cmd_start = wr_commit & (paddr == `RSSOPS_CMD_OFF);

  // Bus and status outputs
  assign pready = 1'b1; // No wait states
  assign prdata = rdata_reg;
  assign pslverr = err_reg & penable;
  assign busy = (state_reg != RSSOPS_IDLE);
  assign skip_cycle = (state_reg == RSSOPS_DUMMY);

  always_comb
  begin
    hit = 1'b1;
    if (paddr == `RSSOPS_CMD_OFF)
      hit = 1'b1;
    else if (paddr == `RSSOPS_WORK_OFF)
      hit = 1'b1;
    else if (paddr == `RSSOPS_MEM_OFF)
      hit = 1'b1;
    else if (paddr == `RSSOPS_STAT_OFF)
      hit = 1'b1;
    else
      hit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Subtract with borrow datapath
  always_comb
  begin
    operand = (op_reg == RSSOPS_OP_SUBB_IMM) ? imm_reg : mem_reg; // RULE5
    diff9 = {1'b0, work_reg} - {1'b0, operand}
      - {8'h00, ~flag_reg.borrow_inverse_bit}; // RULE3
    sub_res = diff9[7:0];
    low5 = {1'b0, work_reg[3:0]} - {1'b0, operand[3:0]}
      - {4'h0, ~flag_reg.borrow_inverse_bit};
    sub_ov = (work_reg[7] ^ operand[7]) & (work_reg[7] ^ sub_res[7]);
    sub_flags.borrow_inverse_bit = ~diff9[8]; // RULE4
    sub_flags.result_null_flag = (sub_res == 8'h00);
    sub_flags.nibble_borrow_flag = ~low5[4];
    sub_flags.signed_range_flag = sub_ov;
    sub_flags.signed_borrow_flag = sub_ov ^ sub_res[7];
    sub_flags.chained_null_flag = (sub_res == 8'h00) & flag_reg.chained_null_flag;
    dec_src = mem_reg;
    dec_res = dec_src - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Rotate and decrement datapath
  always_comb
  begin
    rot_res = {flag_reg.borrow_inverse_bit, mem_reg[7:1]}; // RULE1
    rot_borrow = mem_reg[0]; // RULE1
    dec_zero = (dec_res == 8'h00); // RULE8 RULE10
    skip_req = 1'b0;
    if (op_reg == RSSOPS_OP_DEC_SKIP)
      skip_req = dec_zero; // RULE8
    else if (op_reg == RSSOPS_OP_DEC_WORK_SKIP)
      skip_req = dec_zero; // RULE10
  end

  ////////////////////////////////////////////////////////////////////////
  // Layout checks: the flag struct must fill the status field exactly
  generate
    if ($bits(rssops_flags_t) != (`RSSOPS_STAT_FLAG_MSB + 1))
    begin : g_flag_width
      $error("flag struct width differs from the status flag field");
    end
    if (`RSSOPS_STAT_BUSY_BIT <= `RSSOPS_STAT_FLAG_MSB)
    begin : g_busy_place
      $error("busy bit overlaps the status flag field");
    end
    if (`RSSOPS_STAT_SKIP_BIT == `RSSOPS_STAT_BUSY_BIT)
    begin : g_skip_place
      $error("skip bit shares the busy bit");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state: one execute cycle, then a dummy cycle on a skip
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RSSOPS_IDLE:
      begin
        if (cmd_start)
          state_next = RSSOPS_EXEC;
      end
      RSSOPS_EXEC:
      begin
        if (skip_req)
          state_next = RSSOPS_DUMMY; // RULE9
        else
          state_next = RSSOPS_IDLE;
      end
      RSSOPS_DUMMY:
        state_next = RSSOPS_IDLE; // RULE9 RULE12
      default:
        state_next = RSSOPS_IDLE;
    endcase
  end

  // Sequencer register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= RSSOPS_IDLE;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file next values: software writes when idle, results in EXEC
  always_comb
  begin
    work_next = work_reg;
    mem_next = mem_reg;
    flag_next = flag_reg;
    op_next = op_reg;
    imm_next = imm_reg;
    case (state_reg)
      RSSOPS_IDLE:
      begin
        if (wr_commit)
        begin
          if (paddr == `RSSOPS_CMD_OFF)
          begin
            op_next = rssops_op_t'(pwdata[`RSSOPS_CMD_OP_MSB:`RSSOPS_CMD_OP_LSB]);
            imm_next = pwdata[`RSSOPS_CMD_IMM_MSB:`RSSOPS_CMD_IMM_LSB];
          end
          else if (paddr == `RSSOPS_WORK_OFF)
            work_next = pwdata[`RSSOPS_DATA_MSB:0];
          else if (paddr == `RSSOPS_MEM_OFF)
            mem_next = pwdata[`RSSOPS_DATA_MSB:0];
          else if (paddr == `RSSOPS_STAT_OFF)
            flag_next = rssops_flags_t'(pwdata[`RSSOPS_STAT_FLAG_MSB:0]);
        end
      end
      RSSOPS_EXEC:
      begin
        case (op_reg)
          RSSOPS_OP_ROT_RC_WORK:
          begin
            work_next = rot_res; // RULE1 RULE2
            flag_next.borrow_inverse_bit = rot_borrow; // RULE1 RULE2
          end
          RSSOPS_OP_SUBB_MEM, RSSOPS_OP_SUBB_IMM:
          begin
            work_next = sub_res; // RULE3 RULE5
            flag_next = sub_flags; // RULE4 RULE7
          end
          RSSOPS_OP_SUBB_TO_MEM:
          begin
            mem_next = sub_res; // RULE6
            flag_next = sub_flags; // RULE4 RULE7
          end
          RSSOPS_OP_DEC_SKIP:
            mem_next = dec_res; // RULE8 RULE11
          RSSOPS_OP_DEC_WORK_SKIP:
            work_next = dec_res; // RULE10 RULE11
          default:
            op_next = op_reg; // Unused codes change nothing
        endcase
      end
      default:
        op_next = op_reg; // RULE12
    endcase
  end

  // Register file registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_reg <= `RSSOPS_WORK_RST;
      mem_reg <= `RSSOPS_MEM_RST;
      flag_reg <= `RSSOPS_FLAG_RST;
      op_reg <= RSSOPS_OP_NONE;
      imm_reg <= `RSSOPS_IMM_RST;
    end
    else
    begin
      work_reg <= work_next;
      mem_reg <= mem_next;
      flag_reg <= flag_next;
      op_reg <= op_next;
      imm_reg <= imm_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer: status word gathers flags, busy and skip
  always_comb
  begin
    stat_word = `RSSOPS_RDATA_RST;
    stat_word[`RSSOPS_STAT_FLAG_MSB:0] = flag_reg;
    stat_word[`RSSOPS_STAT_BUSY_BIT] = busy;
    stat_word[`RSSOPS_STAT_SKIP_BIT] = skip_cycle;
    rd_word = `RSSOPS_RDATA_RST; // Unmapped offsets read zero
    if (paddr == `RSSOPS_CMD_OFF)
      rd_word = {16'h0000, imm_reg, 5'h00, op_reg};
    else if (paddr == `RSSOPS_WORK_OFF)
      rd_word = {24'h000000, work_reg};
    else if (paddr == `RSSOPS_MEM_OFF)
      rd_word = {24'h000000, mem_reg};
    else if (paddr == `RSSOPS_STAT_OFF)
      rd_word = stat_word;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus next values: refusal and read data are taken at the setup edge
  always_comb
  begin
    err_next = 1'b0;
    if (refuse)
      err_next = 1'b1; // Unmapped, or a write while busy
    rdata_next = rdata_reg;
    if (setup_rd)
      rdata_next = rd_word;
  end

  // Bus registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= `RSSOPS_RDATA_RST;
      err_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

endmodule

// ===== hdl/rssops_regs.svh
// Purpose: Register offsets, field positions and reset values of the slice.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef RSSOPS_REGS_SVH
`define RSSOPS_REGS_SVH

// Register byte offsets
`define RSSOPS_CMD_OFF 12'h000
`define RSSOPS_WORK_OFF 12'h004
`define RSSOPS_MEM_OFF 12'h008
`define RSSOPS_STAT_OFF 12'h00C

// Command register fields
`define RSSOPS_CMD_OP_LSB 0
`define RSSOPS_CMD_OP_MSB 2
`define RSSOPS_CMD_IMM_LSB 8
`define RSSOPS_CMD_IMM_MSB 15

// Status register fields
`define RSSOPS_STAT_FLAG_MSB 5
`define RSSOPS_STAT_BUSY_BIT 8
`define RSSOPS_STAT_SKIP_BIT 9

// Data byte field of the work and memory registers
`define RSSOPS_DATA_MSB 7

// Reset values
`define RSSOPS_RDATA_RST 32'h0000_0000
`define RSSOPS_WORK_RST 8'h00
`define RSSOPS_MEM_RST 8'h00
`define RSSOPS_FLAG_RST 6'h00
`define RSSOPS_IMM_RST 8'h00

`endif

// ===== hdl/rssops_pkg.sv
// Purpose: Types shared by the rotate, subtract and skip slice.
// Assumes: Nothing beyond the register header.
// Notes: Flag struct order matches status bits 5..0.
package rssops_pkg;

  // Operation selected by the command register
  typedef enum logic [2:0] {
    RSSOPS_OP_NONE,
    RSSOPS_OP_ROT_RC_WORK,
    RSSOPS_OP_SUBB_MEM,
    RSSOPS_OP_SUBB_IMM,
    RSSOPS_OP_SUBB_TO_MEM,
    RSSOPS_OP_DEC_SKIP,
    RSSOPS_OP_DEC_WORK_SKIP
  } rssops_op_t;

  // Status flags, bit 5 down to bit 0
  typedef struct packed {
    logic chained_null_flag;
    logic signed_borrow_flag;
    logic signed_range_flag;
    logic nibble_borrow_flag;
    logic result_null_flag;
    logic borrow_inverse_bit;
  } rssops_flags_t;

  // Sequencer states
  typedef enum logic [1:0] {
    RSSOPS_IDLE,
    RSSOPS_EXEC,
    RSSOPS_DUMMY
  } rssops_state_t;

endpackage

// ===== verification/rssops_asserts.sv
// Purpose: Port checks of the rotate, subtract and skip slice.
// Assumes: Reads and refusals judged at setup, writes land at access.
// Notes: Sees only top ports.
`timescale 1ns/100ps
`include "rssops_regs.svh"
module rssops_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Status
  input wire logic busy,
  input wire logic skip_cycle
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase
  wire setup = psel && !penable;
  // Skip and busy timing
  a_skip_one_shot: assert property (skip_cycle |=> !skip_cycle)
    else $error("skip cycle held");
  a_skip_after_exec: assert property (skip_cycle |-> $past(busy) && !$past(skip_cycle))
    else $error("skip without exec");
  a_dummy_ends: assert property (skip_cycle |-> busy ##1 !busy)
    else $error("dummy cycle overrun");
  a_busy_bounded: assert property (busy |-> ##[1:2] !busy)
    else $error("busy too long");
  a_cmd_starts: assert property (psel && penable && pwrite && !pslverr
    && paddr == `RSSOPS_CMD_OFF |=> busy)
    else $error("command did not start");
  a_refuse_busy: assert property (setup && pwrite && busy |=> pslverr)
    else $error("write during op accepted");
  a_stat_busy: assert property (setup && !pwrite && paddr == `RSSOPS_STAT_OFF |=> prdata[8] == $past(busy))
    else $error("busy bit wrong");
  a_stat_skip: assert property (setup && !pwrite && paddr == `RSSOPS_STAT_OFF |=> prdata[9] == $past(skip_cycle))
    else $error("skip bit wrong");
  // Main scenarios
  c_skip: cover property (skip_cycle);
  c_refused: cover property (setup && pwrite && busy);
  c_op_done: cover property (busy ##1 !busy);
endmodule

// ===== verification/tb_rotate_subtract_skip_ops.sv
// Purpose: Self-checking bench of the rotate, subtract and skip slice.
// Assumes: Zero wait-state APB; commands start while idle.
// Notes: Subtract and decrement results come from a local model of the arithmetic; rotate results are fixed values.
`timescale 1ns/100ps
`include "rssops_regs.svh"
module tb_rotate_subtract_skip_ops;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, busy;
  logic skip_cycle, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [2:0] op;
  logic [7:0] a, b;
  logic [5:0] f;
  logic [13:0] x;
  int fails = 0, compares = 0, cyc = 0, nb = 0;
  // Subtract cases: op, work, operand, flags
  logic [24:0] sv [0:4] = '{{3'h2, 16'h1020, 6'h01}, {3'h3, 16'h8001, 6'h01},
    {3'h4, 16'h0504, 6'h20}, {3'h2, 16'h0000, 6'h00}, {3'h3, 16'h3C0F, 6'h21}};
  // Decrement cases: op, memory byte
  logic [10:0] dv [0:3] = '{{3'h5, 8'h01}, {3'h5, 8'h00}, {3'h6, 8'h01}, {3'h6, 8'h05}};
  rssops_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .skip_cycle(skip_cycle));
  // Clock
  always #5 pclk = ~pclk;
  // Busy cycle count and timeout
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    nb <= nb + busy;
    if (cyc == 2000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] w);
    compares++;
    if (s !== w)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, w, s);
    end
  endtask
  // One APB transfer; b2b keeps psel for a following setup
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input bit b2b);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    if (!b2b)
    begin
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'h1, ad, d, 1'h0);
  endtask
  task automatic rdc(input string n, input logic [11:0] ad, input logic [31:0] w);
    apb(1'h0, ad, 32'h0, 1'h0);
    chk(n, r, w);
  endtask
  // Command with count of busy cycles
  task automatic cmd(input logic [31:0] c, input int n);
    int n0;
    n0 = nb;
    wr(`RSSOPS_CMD_OFF, c);
    while (busy) @(posedge pclk);
    @(posedge pclk);
    chk("busy cycles", nb - n0, n);
  endtask
  // Difference and flags {cz, sc, ov, ac, z, c}
  function automatic logic [13:0] subref(input logic [7:0] p, input logic [7:0] q,
    input logic [5:0] g);
    logic [8:0] d;
    logic [4:0] h;
    logic v;
    d = {1'h0, p} - q - !g[0];
    h = {1'h0, p[3:0]} - q[3:0] - !g[0];
    v = (p[7] ^ q[7]) & (d[7] ^ p[7]);
    subref = {d[7:0], d[7:0] == 8'h0 && g[5], v ^ d[7], v, !h[4], d[7:0] == 8'h0, !d[8]};
  endfunction
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdc("work", `RSSOPS_WORK_OFF, 32'h0);
    rdc("stat", `RSSOPS_STAT_OFF, 32'h0);
    $display("test reset done");
    wr(`RSSOPS_MEM_OFF, 32'h80);
    wr(`RSSOPS_STAT_OFF, 32'h15);
    cmd(32'h1, 1);
    rdc("rot work", `RSSOPS_WORK_OFF, 32'hC0);
    rdc("rot mem", `RSSOPS_MEM_OFF, 32'h80);
    rdc("rot stat", `RSSOPS_STAT_OFF, 32'h14);
    $display("test rotate done");
    foreach (sv[i])
    begin
      {op, a, b, f} = sv[i];
      x = subref(a, b, f);
      wr(`RSSOPS_WORK_OFF, {24'h0, a});
      wr(`RSSOPS_MEM_OFF, {24'h0, op == 3'h3 ? 8'h5A : b});
      wr(`RSSOPS_STAT_OFF, {26'h0, f});
      cmd({16'h0, b, 5'h0, op}, 1);
      rdc("sub work", `RSSOPS_WORK_OFF, {24'h0, op == 3'h4 ? a : x[13:6]});
      rdc("sub mem", `RSSOPS_MEM_OFF, {24'h0, op == 3'h4 ? x[13:6] : op == 3'h3 ? 8'h5A : b});
      rdc("sub flags", `RSSOPS_STAT_OFF, {26'h0, x[5:0]});
    end
    $display("test subtract done");
    foreach (dv[i])
    begin
      {op, b} = dv[i];
      a = b - 8'h1;
      wr(`RSSOPS_WORK_OFF, 32'h33);
      wr(`RSSOPS_MEM_OFF, {24'h0, b});
      wr(`RSSOPS_STAT_OFF, 32'h2A);
      cmd({29'h0, op}, a == 8'h0 ? 2 : 1);
      rdc("dec work", `RSSOPS_WORK_OFF, {24'h0, op == 3'h6 ? a : 8'h33});
      rdc("dec mem", `RSSOPS_MEM_OFF, {24'h0, op == 3'h5 ? a : b});
      rdc("dec flags", `RSSOPS_STAT_OFF, 32'h2A);
    end
    $display("test decrement done");
    wr(`RSSOPS_MEM_OFF, 32'h1);
    apb(1'h1, `RSSOPS_CMD_OFF, 32'h5, 1'h1);
    apb(1'h1, `RSSOPS_WORK_OFF, 32'h77, 1'h0);
    chk("refused", {31'h0, e}, 32'h1);
    rdc("dummy work", `RSSOPS_WORK_OFF, 32'h04);
    apb(1'h0, 12'h010, 32'h0, 1'h0);
    chk("unmapped", {r[30:0], e}, 32'h1);
    wr(`RSSOPS_MEM_OFF, 32'h1);
    wr(`RSSOPS_CMD_OFF, 32'h5);
    rdc("skip stat", `RSSOPS_STAT_OFF, 32'h32A);
    $display("test refusal done");
    report_and_stop();
  end
endmodule
bind rssops_core rssops_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .busy(busy), .skip_cycle(skip_cycle));
